// *** logic/hdq_cmd56.sv ***
// general-command decoder returning the health statistics block
//
// Summary of operation
// [RULE1] argument bit 0 one means read
// [RULE2] argument bits 7:1 are function index
// [RULE3] read with index 0x10 returns stats block
// [RULE4] write with index 0x08 prepares stats
// [RULE5] bytes 1..3 of argument are function arguments
// [RULE6] host sends pre-load first, then get
// [RULE7] pre-load step returns no data
// [RULE8] get returns exactly one 512-byte sector
// [RULE9] identity and revision fields at bytes 0..14
// [RULE10] bad-block fields at bytes 16..65
// [RULE11] erase counts and life at bytes 80..109
// [RULE12] power and refresh counts at 112..161
// [RULE13] marker and second die table 176..215
// [RULE14] reserved bytes read as zero
// [RULE15] other index or direction gives no data
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
module hdq_cmd56 (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire logic [31:0] i_cmd_arg,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_reject,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_rd_last,
    input wire logic i_rd_ready,
    input wire logic [hdq_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [hdq_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    import hdq_pkg::*;

    hdq_state_e state_reg;
    logic [8:0] cnt_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] last_arg_reg;
    logic prep_reg;
    logic unsup_reg;
    logic order_reg;
    logic [31:0] stats_mem [STATS_WORDS];
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg;
    logic w_held_reg;

    ////////////////////////////////////////////////////////////////////
    // byte layout of the answer block
    function automatic logic is_field(input logic [8:0] k);
        logic f;
        f = (k <= 9'd12) || (k == 9'd14);                   // RULE9
        f = f || (k >= 9'd16 && k <= 9'd17);                // RULE10
        f = f || (k >= 9'd32 && k <= 9'd65);                // RULE10
        f = f || (k >= 9'd80 && k <= 9'd83);                // RULE11
        f = f || (k >= 9'd96 && k <= 9'd109);               // RULE11
        f = f || (k >= 9'd112 && k <= 9'd115);              // RULE12
        f = f || (k >= 9'd128 && k <= 9'd129);              // RULE12
        f = f || (k >= 9'd160 && k <= 9'd161);              // RULE12
        f = f || (k >= 9'd176 && k <= 9'd215);              // RULE13
        return f;
    endfunction

    // gaps between fields go out as zero whatever software stored
    function automatic logic [7:0] block_byte(input logic [8:0] k);
        logic [31:0] w;
        w = stats_mem[k[7:2]];
        if (k < 9'(STAT_BYTES) && is_field(k)) begin
            return w[8*k[1:0] +: 8];
        end
        return 8'h00;                                       // RULE14
    endfunction

    ////////////////////////////////////////////////////////////////////
    // command decode
    wire cmd_take = i_cmd_valid && o_cmd_ready;
    wire cmd_read = i_cmd_arg[DIR_BIT];                     // RULE1
    wire [6:0] cmd_idx = i_cmd_arg[IDX_LSB +: 7];           // RULE2
    wire cmd_en = ctrl_reg[CTRL_EN_BIT];
    wire is_get = cmd_en && cmd_read && cmd_idx == IDX_GET; // RULE3
    wire is_pre = cmd_en && !cmd_read
        && cmd_idx == IDX_PRELOAD;                          // RULE4
    // a get before any pre-load has nothing prepared to return
    wire get_ok = is_get && prep_reg;                       // RULE6
    wire start_send = cmd_take && get_ok;
    wire bad_cmd = cmd_take && !is_pre && !get_ok;          // RULE15
    wire beat = o_rd_valid && i_rd_ready;
    wire [8:0] cnt_inc = cnt_reg + 9'd1;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 9'h000;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_rd_last <= 1'b0;
            o_cmd_ready <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_send) begin                   // RULE3
                        state_reg <= ST_SEND;
                        cnt_reg <= 9'h000;
                        o_rd_valid <= 1'b1;
                        o_rd_data <= block_byte(9'h000);
                        o_cmd_ready <= 1'b0;
                    end
                end
                ST_SEND: begin
                    if (beat && o_rd_last) begin            // RULE8
                        state_reg <= ST_IDLE;
                        o_rd_valid <= 1'b0;
                        o_rd_last <= 1'b0;
                        o_cmd_ready <= 1'b1;
                    end else if (beat) begin
                        cnt_reg <= cnt_inc;
                        o_rd_data <= block_byte(cnt_inc);
                        o_rd_last <= cnt_inc == LAST_BYTE;  // RULE8
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cmd_done <= 1'b0;
            o_cmd_reject <= 1'b0;
            last_arg_reg <= 32'h0000_0000;
        end else begin
            o_cmd_done <= cmd_take && !bad_cmd;
            o_cmd_reject <= bad_cmd;
            if (cmd_take) begin
                last_arg_reg <= i_cmd_arg;                  // RULE5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register slave
    wire wr_go = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
    wire w_stats = awaddr_reg[11:8] == STATS_PAGE
        && awaddr_reg[7:2] < 6'(STATS_WORDS);
    wire w_ctrl = awaddr_reg == REG_CTRL;
    wire w_stat = awaddr_reg == REG_STATUS;
    wire w_ok = w_stats || w_ctrl || w_stat || awaddr_reg == REG_LAST_ARG;
    wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [31:0] wbits = wdata_reg & wmask;
    // write one to clear; a fresh event in the same cycle wins
    wire clr_unsup = wr_go && w_stat && wbits[ST_UNSUP_BIT];
    wire clr_order = wr_go && w_stat && wbits[ST_ORDER_BIT];
    wire set_order = cmd_take && is_get && !prep_reg;
    wire r_stats = i_s_axi_araddr[11:8] == STATS_PAGE
        && i_s_axi_araddr[7:2] < 6'(STATS_WORDS);
    wire [31:0] status_word = {28'h000_0000, order_reg, unsup_reg,
        state_reg == ST_SEND, prep_reg};
    wire r_ctrl = i_s_axi_araddr == REG_CTRL;
    wire r_stat = i_s_axi_araddr == REG_STATUS;
    wire r_arg = i_s_axi_araddr == REG_LAST_ARG;
    wire r_ok = r_stats || r_ctrl || r_stat || r_arg;
    wire [31:0] rd_word = r_stats ? stats_mem[i_s_axi_araddr[7:2]]
        : r_ctrl ? ctrl_reg : r_stat ? status_word
        : r_arg ? last_arg_reg : 32'h0000_0000;
    wire ar_take = i_s_axi_arvalid && o_s_axi_arready;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                awaddr_reg <= i_s_axi_awaddr;
                aw_held_reg <= 1'b1;
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                wdata_reg <= i_s_axi_wdata;
                wstrb_reg <= i_s_axi_wstrb;
                w_held_reg <= 1'b1;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg <= CTRL_RESET;
            prep_reg <= 1'b0;
            unsup_reg <= 1'b0;
            order_reg <= 1'b0;
            for (int i = 0; i < STATS_WORDS; i++) begin
                stats_mem[i] <= 32'h0000_0000;
            end
        end else begin
            if (wr_go && w_ctrl) begin
                ctrl_reg <= (ctrl_reg & ~wmask) | wbits;
            end
            // the statistics stay live; software should not rewrite
            // them while a block is going out
            if (wr_go && w_stats) begin
                stats_mem[awaddr_reg[7:2]] <=
                    (stats_mem[awaddr_reg[7:2]] & ~wmask) | wbits;
            end
            if (cmd_take && is_pre) begin
                prep_reg <= 1'b1;                           // RULE4
            end
            unsup_reg <= bad_cmd || (unsup_reg && !clr_unsup);
            order_reg <= set_order || (order_reg && !clr_order);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_word;
                o_s_axi_rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_dir_selects: assert property ( // RULE1
        @(posedge i_clk) disable iff (i_reset)
        cmd_take && !i_cmd_arg[DIR_BIT] |=> !o_rd_valid)
        else $error("write-direction command started data");
    a_index_decode: assert property ( // RULE2
        @(posedge i_clk) disable iff (i_reset)
        start_send |-> i_cmd_arg[7:1] == 7'h10)
        else $error("block started for wrong index");
    a_get_starts: assert property ( // RULE3
        @(posedge i_clk) disable iff (i_reset)
        start_send |=> o_rd_valid && cnt_reg == 9'h000)
        else $error("get did not start the block");
    a_preload_flag: assert property ( // RULE4 RULE7
        @(posedge i_clk) disable iff (i_reset)
        cmd_take && is_pre |=> prep_reg && !o_rd_valid)
        else $error("pre-load did not prepare or sent data");
    a_args_kept: assert property ( // RULE5
        @(posedge i_clk) disable iff (i_reset)
        cmd_take |=> last_arg_reg[31:8] == $past(i_cmd_arg[31:8]))
        else $error("function arguments not captured");
    a_order_flag: assert property ( // RULE6
        @(posedge i_clk) disable iff (i_reset)
        cmd_take && is_get && !prep_reg |=> order_reg && !o_rd_valid)
        else $error("get before pre-load not refused");
    a_block_end: assert property ( // RULE8
        @(posedge i_clk) disable iff (i_reset)
        o_rd_last |-> o_rd_valid && cnt_reg == LAST_BYTE)
        else $error("last marker not on byte 511");
    a_beat_hold: assert property ( // RULE8
        @(posedge i_clk) disable iff (i_reset)
        o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data)
            && $stable(cnt_reg))
        else $error("byte changed while stalled");
    a_reserved_zero: assert property ( // RULE14
        @(posedge i_clk) disable iff (i_reset)
        o_rd_valid && (cnt_reg >= 9'(STAT_BYTES) || cnt_reg == 9'd13)
            |-> o_rd_data == 8'h00)
        else $error("reserved byte not zero");
    a_unsup_flag: assert property ( // RULE15
        @(posedge i_clk) disable iff (i_reset)
        bad_cmd |=> unsup_reg && o_cmd_reject && !o_rd_valid)
        else $error("unsupported command not flagged");
endmodule

// *** logic/hdq_pkg.sv ***
// constants and types of the general-command health query block
package hdq_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_LAST_ARG = 12'h008;
    localparam logic [3:0] STATS_PAGE = 4'h1;
    localparam int STATS_WORDS = 54;
    localparam int STAT_BYTES = 216;
    localparam int BLOCK_BYTES = 512;
    localparam logic [8:0] LAST_BYTE = 9'h1FF;
    localparam logic [6:0] IDX_GET = 7'h10;
    localparam logic [6:0] IDX_PRELOAD = 7'h08;
    localparam int DIR_BIT = 0;
    localparam int IDX_LSB = 1;
    localparam int ARG1_LSB = 8;
    localparam int ARG2_LSB = 16;
    localparam int ARG3_LSB = 24;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int ST_PREP_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_UNSUP_BIT = 2;
    localparam int ST_ORDER_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } hdq_state_e;
endpackage

// *** tb/hdq_host_model.sv ***
// host-side model that issues general commands and sinks the block
module hdq_host_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_cmd_ready,
    input wire logic i_cmd_done,
    input wire logic i_cmd_reject,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_last,
    output logic o_cmd_valid,
    output logic [31:0] o_cmd_arg,
    output logic o_rd_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    int last_at = -1;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_arg = 32'h0000_0000;
        o_rd_ready = 1'b0;
    end
    // alternate stalls force the card to hold each byte until taken
    always @(posedge i_clk) o_rd_ready <= i_stall ? ~o_rd_ready : 1'b1;
    always @(negedge i_clk) begin
        if (i_rd_valid && o_rd_ready) begin
            if (i_rd_last) last_at = got_q.size();
            got_q.push_back(i_rd_data);
        end
    end
    // res is {done, reject} as seen in the cycle after the take
    task automatic send(input logic [31:0] arg, output logic [1:0] res);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_arg <= arg;
        do @(negedge i_clk); while (!i_cmd_ready);
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        // released argument must not look like the old one
        o_cmd_arg <= ~arg;
        @(negedge i_clk);
        res = {i_cmd_done, i_cmd_reject};
    endtask
endmodule

// *** tb/tb_health_data_query_cmd.sv ***
// self-checking bench for the general-command health query block
module tb_health_data_query_cmd;
    timeunit 1ns;
    timeprecision 1ps;
    import hdq_pkg::*;
    logic i_clk, i_reset, stall, cvalid, cready, done, rej, rvld, rlast, rrdy;
    logic [7:0] rbyte;
    logic [31:0] carg, wdata, rdata, d;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, res, r;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    hdq_cmd56 u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(cvalid),
        .i_cmd_arg(carg), .o_cmd_ready(cready), .o_cmd_done(done),
        .o_cmd_reject(rej), .o_rd_valid(rvld), .o_rd_data(rbyte),
        .o_rd_last(rlast), .i_rd_ready(rrdy), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready));
    hdq_host_model u_host (.i_clk(i_clk), .i_stall(stall),
        .i_cmd_ready(cready), .i_cmd_done(done), .i_cmd_reject(rej),
        .i_rd_valid(rvld), .i_rd_data(rbyte), .i_rd_last(rlast),
        .o_cmd_valid(cvalid), .o_cmd_arg(carg), .o_rd_ready(rrdy));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        logic ah, wh;
        ah = 1'b0;
        wh = 1'b0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // the slave may take address and data on different edges
        while (!(ah && wh)) begin
            @(negedge i_clk);
            @(posedge i_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            ah = ah || (awvalid && awready);
            wh = wh || (wvalid && wready);
        end
        while (!bvalid) @(negedge i_clk);
        r = bresp;
        @(posedge i_clk);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge i_clk); while (!arready);
        @(posedge i_clk);
        arvalid <= 1'b0;
        do @(negedge i_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge i_clk);
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] pat(input int i);
        return {8'(i + 1), 8'(i + 2), 8'(i + 3), 8'(i + 4)};
    endfunction
    function automatic logic [7:0] exp_byte(input int k);
        logic [31:0] w;
        w = pat(k / 4);
        if (k inside {13, 15, [18:31], [66:79], [84:95], [110:111],
            [116:127], [130:159], [162:175]} || k >= STAT_BYTES)
            return 8'h00;
        return w[8 * (k % 4) +: 8];
    endfunction
    task automatic t_regs();
        axi_rd(REG_CTRL);
        check(d, CTRL_RESET);
        for (int i = 0; i < STATS_WORDS; i++)
            axi_wr({STATS_PAGE, 8'(4 * i)}, pat(i));
        check(r, RESP_OKAY);
        axi_rd(12'h10C);
        check(d, pat(3));
        axi_rd(12'hFFC);
        check(r, RESP_SLVERR);
        axi_wr(12'hFF8, 32'h0000_0000);
        check(r, RESP_SLVERR);
    endtask
    task automatic t_order();
        u_host.send(32'h0000_0021, res);
        check(res, 2'b01);
        axi_rd(REG_STATUS);
        check(d, 32'h0000_000C);
        axi_wr(REG_STATUS, 32'h0000_000C);
        axi_rd(REG_STATUS);
        check(d, 32'h0000_0000);
    endtask
    task automatic t_unsup();
        logic [31:0] bad[4] = '{32'h0000_0011, 32'h0000_0020,
            32'h0000_0023, 32'hFFEE_DD00};
        foreach (bad[i]) begin
            u_host.send(bad[i], res);
            check(res, 2'b01);
        end
        axi_rd(REG_LAST_ARG);
        check(d, 32'hFFEE_DD00);
        axi_wr(REG_CTRL, 32'h0000_0000);
        u_host.send(32'h0000_0010, res);
        check(res, 2'b01);
        axi_wr(REG_CTRL, CTRL_RESET);
        axi_rd(REG_STATUS);
        check(d, 32'h0000_0004);
        check(u_host.got_q.size(), 0);
    endtask
    task automatic t_preload();
        u_host.send(32'h0000_0010, res);
        check(res, 2'b10);
        check(u_host.got_q.size(), 0);
        axi_rd(REG_STATUS);
        check(d, 32'h0000_0005);
        axi_rd(REG_LAST_ARG);
        check(d, 32'h0000_0010);
    endtask
    task automatic t_get(input logic s);
        @(posedge i_clk);
        stall <= s;
        u_host.got_q.delete();
        u_host.last_at = -1;
        u_host.send(32'h0000_0021, res);
        check(res, 2'b10);
        while (!cready) @(negedge i_clk);
        check(u_host.got_q.size(), BLOCK_BYTES);
        check(u_host.last_at, 511);
        for (int k = 0; k < BLOCK_BYTES; k++) begin
            d = {24'h00_0000, exp_byte(k)};
            if (k < 80)
                check(u_host.got_q[k], d);
            else if (k < 176)
                check(u_host.got_q[k], d);
            else
                check(u_host.got_q[k], d);
        end
    endtask
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // a hung handshake ends the run through the same report
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        i_reset = 1'b1;
        {stall, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_order();
        t_unsup();
        t_preload();
        t_get(1'b1);
        t_get(1'b0);
        wrap_up();
    end
endmodule
